//--- clone_security_regs.svh
// Parameter numbers, limits and reset values of the clone and security block
// Assumes parameters are addressed as menu*100+number on a 12-bit port
`ifndef CLONE_SECURITY_REGS_SVH
`define CLONE_SECURITY_REGS_SVH
// ----------------------------------------
// Parameter addresses
// ----------------------------------------
`define ADDR_RESET_FLAG 12'h409
`define ADDR_ACTION_CODE 12'h40e
`define ADDR_SECURITY_CODE 12'h46a
`define ADDR_RATED_CURRENT 12'h46c
`define ADDR_VOLTAGE_RATING 12'h46d
`define ADDR_SW_SUBVERSION 12'h46e
`define ADDR_SP_VERSION 12'h46f
`define ADDR_REVERT_TIMEOUT 12'h475
`define ADDR_CLONE_MODE 12'h476
// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define SECURITY_RST 16'h0000
`define SECURITY_MAX 16'h270f
`define TIMEOUT_RST 8'hf0
`define TIMEOUT_MAX 8'hfa
`define CURRENT_MIN 16'h0096
`define CURRENT_MAX 16'h1b58
`define VOLTAGE_MIN 16'h00f0
`define VOLTAGE_MAX 16'h01e0
`define SUBVERSION_MAX 8'h63
`define SP_VERSION_MAX 8'h63
`define RESET_FLAG_GO 16'h0001
`define ACTION_RESET 16'h0064
// ----------------------------------------
// Key memory layout
// ----------------------------------------
`define KEY_HDR_RATING 0
`define KEY_HDR_MODE 1
`define KEY_PAR_BASE 2
// ----------------------------------------
// Timing
// ----------------------------------------
`define SECOND_NS 1000000000
`define CLK_PERIOD_NS 4
`endif

//--- clone_security_pkg.sv
// Types shared by the clone and security block
// Assumes the register header is compiled alongside
package clone_security_pkg;
  typedef enum logic [2:0] {
    CLONE_NONE = 3'h0,
    CLONE_READ = 3'h1,
    CLONE_PROG = 3'h2,
    CLONE_AUTO = 3'h3,
    CLONE_BOOT = 3'h4
  } clone_mode_type;
  typedef enum logic [2:0] {
    ST_BOOT,
    ST_IDLE,
    ST_LOAD,
    ST_STORE_HDR,
    ST_STORE,
    ST_DONE
  } copy_state_type;
endpackage

//--- nv_param_store.sv
// Nonvolatile parameter image: one write port, one registered read port
// Assumes a single clock; read data appear one cycle after the index
`timescale 1ns/1ps
module nv_param_store #(
  parameter int AW = 6,
  parameter int DW = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_widx,
  input wire logic [DW-1:0] i_wdata,
  input wire logic [AW-1:0] i_ridx,
  output logic [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  always_ff @(posedge i_ref_clk) begin
    if (i_we) begin
      mem[i_widx] <= i_wdata;
    end
    o_rdata <= mem[i_ridx];
  end
endmodule

//--- clone_security_core.sv
// Parameter clone engine, user security lock, display revert and rating readouts
// Assumes a synchronous key memory with one-cycle read latency on the same clock
//
// Behaviour
// R1: Nonzero security code blocks basic parameter writes
// R2: Rated current read-only, 1.50 to 70.00
// R3: Voltage rating read-only, 240 to 480
// R4: Software sub-version read-only, 0 to 99
// R5: Signal processor version read-only, 0 to 9.9
// R6: Revert display after keypad idle timeout
// R7: Mode 1 reset when halted loads key
// R8: Mode 2 reset stores drive to key
// R9: Serial flag, action code, terminal also reset
// R10: Key receives only nonvolatile stored values
// R11: Key header mode: 1,2 become 0
// R12: Rating mismatch skips rating parameters, then trips
// R13: Mode 3 mirrors every save into key
// R14: Key mode 4 loads drive at power-up
`timescale 1ns/1ps
`include "clone_security_regs.svh"
module clone_security_core #(
  parameter int AW = 6,
  parameter int TICKS_PER_SEC = `SECOND_NS / `CLK_PERIOD_NS,
  parameter logic [15:0] RATED_CURRENT = 16'h0096,
  parameter logic [15:0] VOLTAGE_RATING = 16'h00f0,
  parameter logic [7:0] SW_SUBVERSION = 8'h00,
  parameter logic [7:0] SP_VERSION = 8'h00,
  parameter logic [(1<<AW)-1:0] RATING_SPECIFIC = '0
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_par_req,
  input wire logic i_par_we,
  input wire logic [11:0] i_par_addr,
  input wire logic [15:0] i_par_wdata,
  input wire logic i_par_basic,
  output logic o_par_ack,
  output logic o_par_refused,
  output logic [15:0] o_par_rdata,
  input wire logic i_save_we,
  input wire logic [AW-1:0] i_save_idx,
  input wire logic [15:0] i_save_data,
  output logic o_save_ready,
  input wire logic [AW-1:0] i_nv_rd_idx,
  output logic [15:0] o_nv_rd_data,
  input wire logic i_reset_key,
  input wire logic i_reset_terminal,
  input wire logic i_disabled_state,
  input wire logic i_fault_halted_state,
  input wire logic i_standby_state,
  input wire logic i_keypad_activity,
  output logic o_key_re,
  output logic o_key_we,
  output logic [AW:0] o_key_addr,
  output logic [15:0] o_key_wdata,
  input wire logic [15:0] i_key_rdata,
  output logic o_busy,
  output logic o_rating_trip,
  output logic o_status_mode,
  output logic o_user_locked,
  output logic [2:0] o_clone_mode
);
  localparam int N = 1 << AW;
  localparam logic [15:0] CUR_RO = (RATED_CURRENT < `CURRENT_MIN) ? `CURRENT_MIN :
                                   (RATED_CURRENT > `CURRENT_MAX) ? `CURRENT_MAX : RATED_CURRENT;
  localparam logic [15:0] VOLT_RO = (VOLTAGE_RATING < `VOLTAGE_MIN) ? `VOLTAGE_MIN :
                                    (VOLTAGE_RATING > `VOLTAGE_MAX) ? `VOLTAGE_MAX : VOLTAGE_RATING;
  localparam logic [7:0] SUB_RO = (SW_SUBVERSION > `SUBVERSION_MAX) ? `SUBVERSION_MAX : SW_SUBVERSION;
  localparam logic [7:0] SP_RO = (SP_VERSION > `SP_VERSION_MAX) ? `SP_VERSION_MAX : SP_VERSION;
  localparam logic [31:0] TICK_LAST = 32'(TICKS_PER_SEC - 1);
  localparam logic [AW+1:0] CNT_KEY_END = (AW+2)'(N + `KEY_PAR_BASE);
  localparam logic [AW:0] KEY_LAST = (AW+1)'(N + `KEY_PAR_BASE - 1);

  // ----------------------------------------
  // Parameter registers
  // ----------------------------------------
  logic [15:0] sec_ff, nxt_sec;
  logic [7:0] tmo_ff, nxt_tmo;
  clone_security_pkg::clone_mode_type mode_ff, nxt_mode;
  logic ack_ff, nxt_ack, ref_ff, nxt_ref;
  logic [15:0] rdata_ff, nxt_rdata;
  logic wr, blocked, ser_trig, clr_mode;
  always_comb begin
    nxt_sec = sec_ff;
    nxt_tmo = tmo_ff;
    nxt_mode = mode_ff;
    nxt_ack = i_par_req;
    nxt_ref = 1'b0;
    nxt_rdata = rdata_ff;
    ser_trig = 1'b0;
    wr = i_par_req && i_par_we;
    blocked = wr && i_par_basic && (sec_ff != `SECURITY_RST); // R1
    if (blocked) begin
      nxt_ref = 1'b1; // R1
    end else if (i_par_req) begin
      nxt_rdata = 16'h0000;
      unique case (i_par_addr)
        `ADDR_SECURITY_CODE: begin
          nxt_rdata = sec_ff;
          if (wr && i_par_wdata > `SECURITY_MAX) nxt_ref = 1'b1;
          else if (wr) nxt_sec = i_par_wdata;
        end
        `ADDR_RATED_CURRENT: begin
          nxt_rdata = CUR_RO; // R2
          nxt_ref = wr; // R2
        end
        `ADDR_VOLTAGE_RATING: begin
          nxt_rdata = VOLT_RO; // R3
          nxt_ref = wr; // R3
        end
        `ADDR_SW_SUBVERSION: begin
          nxt_rdata = {8'h00, SUB_RO}; // R4
          nxt_ref = wr; // R4
        end
        `ADDR_SP_VERSION: begin
          nxt_rdata = {8'h00, SP_RO}; // R5
          nxt_ref = wr; // R5
        end
        `ADDR_REVERT_TIMEOUT: begin
          nxt_rdata = {8'h00, tmo_ff};
          if (wr && i_par_wdata > {8'h00, `TIMEOUT_MAX}) nxt_ref = 1'b1;
          else if (wr) nxt_tmo = i_par_wdata[7:0];
        end
        `ADDR_CLONE_MODE: begin
          nxt_rdata = {13'h0000, mode_ff};
          if (wr && i_par_wdata > {13'h0000, clone_security_pkg::CLONE_BOOT}) nxt_ref = 1'b1;
          else if (wr) nxt_mode = clone_security_pkg::clone_mode_type'(i_par_wdata[2:0]);
        end
        `ADDR_RESET_FLAG: ser_trig = wr && (i_par_wdata == `RESET_FLAG_GO); // R9
        `ADDR_ACTION_CODE: ser_trig = wr && (i_par_wdata == `ACTION_RESET); // R9
        default: nxt_rdata = 16'h0000;
      endcase
    end
    if (clr_mode) begin
      nxt_mode = clone_security_pkg::CLONE_NONE; // R7 R8
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sec_ff <= `SECURITY_RST;
      tmo_ff <= `TIMEOUT_RST;
      mode_ff <= clone_security_pkg::CLONE_NONE;
      ack_ff <= 1'b0;
      ref_ff <= 1'b0;
      rdata_ff <= 16'h0000;
    end else begin
      sec_ff <= nxt_sec;
      tmo_ff <= nxt_tmo;
      mode_ff <= nxt_mode;
      ack_ff <= nxt_ack;
      ref_ff <= nxt_ref;
      rdata_ff <= nxt_rdata;
    end
  end
  assign o_par_ack = ack_ff;
  assign o_par_refused = ref_ff;
  assign o_par_rdata = rdata_ff;
  assign o_user_locked = (sec_ff != `SECURITY_RST);
  assign o_clone_mode = mode_ff;

  // ----------------------------------------
  // Reset terminal synchroniser
  // ----------------------------------------
  logic term_s1_ff, term_s2_ff, term_s3_ff, trig;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      term_s1_ff <= 1'b0;
      term_s2_ff <= 1'b0;
      term_s3_ff <= 1'b0;
    end else begin
      term_s1_ff <= i_reset_terminal;
      term_s2_ff <= term_s1_ff;
      term_s3_ff <= term_s2_ff;
    end
  end
  assign trig = i_reset_key || ser_trig || (term_s2_ff ^ term_s3_ff); // R9

  // ----------------------------------------
  // Copy engine
  // ----------------------------------------
  clone_security_pkg::copy_state_type st_ff, nxt_st;
  logic [AW+1:0] cnt_ff, nxt_cnt;
  logic key_re_ff, nxt_key_re, key_we_ff, nxt_key_we;
  logic [AW:0] key_addr_ff, nxt_key_addr, rd_addr_ff;
  logic [15:0] key_wdata_ff, nxt_key_wdata;
  logic rd_pend_ff, nv_pend_ff, match_ff, nxt_match, trip_ff, nxt_trip, boot_done_ff, nxt_boot_done;
  logic [AW-1:0] nv_idx_ff, nv_widx, nv_ridx, ld_idx;
  logic nv_we;
  logic [15:0] nv_wdata, nv_rdata;
  logic halted;
  assign halted = i_disabled_state || i_fault_halted_state || i_standby_state;
  assign ld_idx = AW'(rd_addr_ff - (AW+1)'(`KEY_PAR_BASE));
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_key_re = 1'b0;
    nxt_key_we = 1'b0;
    nxt_key_addr = key_addr_ff;
    nxt_key_wdata = key_wdata_ff;
    nxt_match = match_ff;
    nxt_trip = trip_ff;
    nxt_boot_done = boot_done_ff;
    nv_we = 1'b0;
    nv_widx = i_save_idx;
    nv_wdata = i_save_data;
    nv_ridx = i_nv_rd_idx;
    clr_mode = 1'b0;
    unique case (st_ff)
      clone_security_pkg::ST_BOOT: begin
        if (!boot_done_ff) begin
          nxt_boot_done = 1'b1;
          nxt_key_re = 1'b1;
          nxt_key_addr = (AW+1)'(`KEY_HDR_MODE);
        end else if (rd_pend_ff) begin
          nxt_cnt = '0;
          nxt_st = (i_key_rdata[2:0] == clone_security_pkg::CLONE_BOOT) ? clone_security_pkg::ST_LOAD
                                                                          : clone_security_pkg::ST_IDLE; // R14
        end
      end
      clone_security_pkg::ST_IDLE: begin
        nv_we = i_save_we;
        if (i_save_we && mode_ff == clone_security_pkg::CLONE_AUTO) begin
          nxt_key_we = 1'b1; // R13
          nxt_key_addr = (AW+1)'(i_save_idx) + (AW+1)'(`KEY_PAR_BASE); // R13
          nxt_key_wdata = i_save_data; // R13
        end else if (trig && mode_ff == clone_security_pkg::CLONE_READ && halted) begin
          nxt_cnt = '0;
          nxt_trip = 1'b0;
          nxt_st = clone_security_pkg::ST_LOAD; // R7
        end else if (trig && mode_ff == clone_security_pkg::CLONE_PROG) begin
          nxt_cnt = '0;
          nxt_st = clone_security_pkg::ST_STORE_HDR; // R8
        end
      end
      clone_security_pkg::ST_LOAD: begin
        if (cnt_ff != CNT_KEY_END) begin
          nxt_key_re = 1'b1;
          nxt_key_addr = cnt_ff[AW:0];
          nxt_cnt = cnt_ff + 1'b1;
        end
        if (rd_pend_ff && rd_addr_ff == (AW+1)'(`KEY_HDR_RATING)) begin
          nxt_match = (i_key_rdata == CUR_RO); // R12
        end
        if (rd_pend_ff && rd_addr_ff >= (AW+1)'(`KEY_PAR_BASE)) begin
          nv_we = match_ff || !RATING_SPECIFIC[ld_idx]; // R12 R7 R14
          nv_widx = ld_idx;
          nv_wdata = i_key_rdata;
        end
        if (rd_pend_ff && rd_addr_ff == KEY_LAST) begin
          nxt_trip = !match_ff; // R12
          nxt_st = clone_security_pkg::ST_DONE;
        end
      end
      clone_security_pkg::ST_STORE_HDR: begin
        nxt_key_we = 1'b1;
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff == '0) begin
          nxt_key_addr = (AW+1)'(`KEY_HDR_RATING);
          nxt_key_wdata = CUR_RO;
        end else begin
          nxt_key_addr = (AW+1)'(`KEY_HDR_MODE);
          nxt_key_wdata = (mode_ff == clone_security_pkg::CLONE_READ || mode_ff == clone_security_pkg::CLONE_PROG) ?
                          16'h0000 : {13'h0000, mode_ff}; // R11
          nxt_cnt = '0;
          nxt_st = clone_security_pkg::ST_STORE;
        end
      end
      clone_security_pkg::ST_STORE: begin
        nv_ridx = cnt_ff[AW-1:0]; // R10
        if (cnt_ff != (AW+2)'(N)) nxt_cnt = cnt_ff + 1'b1;
        if (nv_pend_ff) begin
          nxt_key_we = 1'b1;
          nxt_key_addr = (AW+1)'(nv_idx_ff) + (AW+1)'(`KEY_PAR_BASE);
          nxt_key_wdata = nv_rdata; // R10
          if (nv_idx_ff == AW'(N - 1)) nxt_st = clone_security_pkg::ST_DONE;
        end
      end
      clone_security_pkg::ST_DONE: begin
        clr_mode = (mode_ff == clone_security_pkg::CLONE_READ || mode_ff == clone_security_pkg::CLONE_PROG); // R7 R8
        nxt_st = clone_security_pkg::ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= clone_security_pkg::ST_BOOT;
      cnt_ff <= '0;
      key_re_ff <= 1'b0;
      key_we_ff <= 1'b0;
      key_addr_ff <= '0;
      key_wdata_ff <= 16'h0000;
      rd_pend_ff <= 1'b0;
      rd_addr_ff <= '0;
      nv_pend_ff <= 1'b0;
      nv_idx_ff <= '0;
      match_ff <= 1'b1;
      trip_ff <= 1'b0;
      boot_done_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      key_re_ff <= nxt_key_re;
      key_we_ff <= nxt_key_we;
      key_addr_ff <= nxt_key_addr;
      key_wdata_ff <= nxt_key_wdata;
      rd_pend_ff <= key_re_ff;
      rd_addr_ff <= key_addr_ff;
      nv_pend_ff <= (st_ff == clone_security_pkg::ST_STORE) && (cnt_ff != (AW+2)'(N));
      nv_idx_ff <= cnt_ff[AW-1:0];
      match_ff <= nxt_match;
      trip_ff <= nxt_trip;
      boot_done_ff <= nxt_boot_done;
    end
  end
  nv_param_store #(.AW(AW), .DW(16)) u_store (
    .i_ref_clk(i_ref_clk),
    .i_we(nv_we),
    .i_widx(nv_widx),
    .i_wdata(nv_wdata),
    .i_ridx(nv_ridx),
    .o_rdata(nv_rdata)
  );
  assign o_nv_rd_data = nv_rdata;
  assign o_save_ready = (st_ff == clone_security_pkg::ST_IDLE);
  assign o_busy = (st_ff != clone_security_pkg::ST_IDLE);
  assign o_key_re = key_re_ff;
  assign o_key_we = key_we_ff;
  assign o_key_addr = key_addr_ff;
  assign o_key_wdata = key_wdata_ff;
  assign o_rating_trip = trip_ff;

  // ----------------------------------------
  // Display revert timer
  // ----------------------------------------
  logic [31:0] tick_ff, nxt_tick;
  logic [7:0] secs_ff, nxt_secs;
  logic stat_ff, nxt_stat;
  always_comb begin
    nxt_tick = tick_ff;
    nxt_secs = secs_ff;
    nxt_stat = stat_ff;
    if (i_keypad_activity) begin
      nxt_stat = 1'b0;
      nxt_tick = 32'h0;
      nxt_secs = 8'h00;
    end else if (!stat_ff) begin
      if (secs_ff >= tmo_ff) begin
        nxt_stat = 1'b1; // R6
      end else if (tick_ff == TICK_LAST) begin
        nxt_tick = 32'h0;
        nxt_secs = secs_ff + 8'h01; // R6
      end else begin
        nxt_tick = tick_ff + 32'h1;
      end
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_ff <= 32'h0;
      secs_ff <= 8'h00;
      stat_ff <= 1'b1;
    end else begin
      tick_ff <= nxt_tick;
      secs_ff <= nxt_secs;
      stat_ff <= nxt_stat;
    end
  end
  assign o_status_mode = stat_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_load_start;
    st_ff == clone_security_pkg::ST_IDLE && trig && !i_save_we && mode_ff == clone_security_pkg::CLONE_READ && halted;
  endsequence
  sequence s_load_run;
    st_ff == clone_security_pkg::ST_LOAD && o_busy;
  endsequence
  property p_lock;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_par_req && i_par_we && i_par_basic && o_user_locked |=> o_par_ack && o_par_refused && $stable(sec_ff);
  endproperty
  a_lock: assert property (p_lock) else $error("locked write accepted"); // R1
  property p_current;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_par_req && i_par_addr == `ADDR_RATED_CURRENT && !blocked |=> o_par_refused == $past(i_par_we)
      && o_par_rdata >= `CURRENT_MIN && o_par_rdata <= `CURRENT_MAX;
  endproperty
  a_current: assert property (p_current) else $error("rated current readout wrong"); // R2
  property p_voltage;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_par_req && i_par_addr == `ADDR_VOLTAGE_RATING && !blocked |=> o_par_rdata >= `VOLTAGE_MIN
      && o_par_rdata <= `VOLTAGE_MAX;
  endproperty
  a_voltage: assert property (p_voltage) else $error("voltage readout out of range"); // R3
  property p_versions;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_par_req && !blocked && (i_par_addr == `ADDR_SW_SUBVERSION || i_par_addr == `ADDR_SP_VERSION)
      |=> o_par_rdata <= {8'h00, `SUBVERSION_MAX};
  endproperty
  a_versions: assert property (p_versions) else $error("version readout out of range"); // R4 R5
  property p_revert;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_keypad_activity |=> !o_status_mode;
  endproperty
  a_revert: assert property (p_revert) else $error("keypad activity ignored"); // R6
  property p_load;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    s_load_start |=> s_load_run ##1 o_key_re && o_key_addr == (AW+1)'(`KEY_HDR_RATING);
  endproperty
  a_load: assert property (p_load) else $error("load did not start"); // R7 R9
  property p_store;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    st_ff == clone_security_pkg::ST_IDLE && trig && !i_save_we && mode_ff == clone_security_pkg::CLONE_PROG
      |=> ##2 o_key_we && o_key_addr == (AW+1)'(`KEY_HDR_MODE) && o_key_wdata == 16'h0000;
  endproperty
  a_store: assert property (p_store) else $error("store header wrong"); // R8 R11
  property p_mirror;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    st_ff == clone_security_pkg::ST_IDLE && i_save_we && mode_ff == clone_security_pkg::CLONE_AUTO
      |=> o_key_we && o_key_wdata == $past(i_save_data);
  endproperty
  a_mirror: assert property (p_mirror) else $error("save not mirrored to key"); // R13
endmodule

//--- key_mem_model.sv
// Behavioural key memory: 128 words, one-cycle read latency
// Assumes the block drives strobes from the same clock
`timescale 1ns/1ps
module key_mem_model (
  input wire logic i_ref_clk,
  input wire logic i_re,
  input wire logic i_we,
  input wire logic [6:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata
);
  logic [15:0] mem [0:127];
  initial o_rdata = 16'h0000;
  // Blank key at power-up
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 16'h0000;
    end
  end
  // ----------------------------------------
  // Word store; data held one cycle only
  // ----------------------------------------
  always @(posedge i_ref_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    if (i_re) begin
      o_rdata <= mem[i_addr];
    end else begin
      o_rdata <= ~o_rdata;
    end
  end
endmodule

//--- tb_top.sv
// Self-checking bench of the clone and security block
// Assumes the key memory model and the design files are compiled first
`timescale 1ns/1ps
`include "clone_security_regs.svh"
module tb_top;
  localparam logic [15:0] RC = 16'h0bb8;
  localparam logic [15:0] VR = 16'h0190;
  localparam logic [7:0] SUB = 8'h07;
  localparam logic [7:0] SPV = 8'h0c;
  logic clk = 1'b0, rst_n = 1'b0, req = 1'b0, we = 1'b0, basic = 1'b0, sv_we = 1'b0;
  logic rkey = 1'b0, rterm = 1'b0, kpad = 1'b0;
  logic [2:0] hs = 3'h0;
  logic [11:0] addr = 12'h000;
  logic [15:0] wd = 16'h0000, sv_d = 16'h0000, krd, p_rd, nv_rd, kwd, nv_exp [0:63];
  logic [5:0] sv_i = 6'h00, nv_i = 6'h00;
  logic [6:0] kaddr;
  logic ack, refd, sv_rdy, kre, kwe, busy, trip, stat, lock;
  logic [2:0] cmode;
  logic [17:0] q [$];
  logic [17:0] e;
  logic [31:0] rs = 32'h6fa79eeb;
  int failures = 0, compares = 0, cyc = 0;
  always #2 clk = ~clk;
  clone_security_core #(.TICKS_PER_SEC(10), .RATED_CURRENT(RC), .VOLTAGE_RATING(VR),
    .SW_SUBVERSION(SUB), .SP_VERSION(SPV), .RATING_SPECIFIC(64'h8)) uut (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_par_req(req), .i_par_we(we), .i_par_addr(addr),
    .i_par_wdata(wd), .i_par_basic(basic), .o_par_ack(ack), .o_par_refused(refd), .o_par_rdata(p_rd),
    .i_save_we(sv_we), .i_save_idx(sv_i), .i_save_data(sv_d), .o_save_ready(sv_rdy),
    .i_nv_rd_idx(nv_i), .o_nv_rd_data(nv_rd), .i_reset_key(rkey), .i_reset_terminal(rterm),
    .i_disabled_state(hs[2]), .i_fault_halted_state(hs[1]), .i_standby_state(hs[0]),
    .i_keypad_activity(kpad), .o_key_re(kre), .o_key_we(kwe), .o_key_addr(kaddr), .o_key_wdata(kwd),
    .i_key_rdata(krd), .o_busy(busy), .o_rating_trip(trip), .o_status_mode(stat),
    .o_user_locked(lock), .o_clone_mode(cmode));
  key_mem_model key (.i_ref_clk(clk), .i_re(kre), .i_we(kwe), .i_addr(kaddr), .i_wdata(kwd), .o_rdata(krd));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[15:0];
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic par(input logic w, input logic [11:0] a, input logic [15:0] d, input logic b,
                     input logic rf, input logic [15:0] rx);
    q.push_back({w, rf, rx});
    @(posedge clk);
    req <= 1'b1;
    we <= w;
    addr <= a;
    wd <= d;
    basic <= b;
    @(posedge clk);
    req <= 1'b0;
  endtask
  task automatic save(input logic [5:0] i, input logic [15:0] d);
    @(posedge clk);
    sv_we <= 1'b1;
    sv_i <= i;
    sv_d <= d;
    nv_exp[i] = d;
    @(posedge clk);
    sv_we <= 1'b0;
  endtask
  task automatic nv_chk(input logic [5:0] i);
    @(posedge clk);
    nv_i <= i;
    @(posedge clk);
    @(negedge clk);
    chk(nv_rd, nv_exp[i]);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (5) @(posedge clk);
    while (busy !== 1'b0 && n < 600) begin
      @(posedge clk);
      n++;
    end
    if (n >= 600) failures++;
    repeat (2) @(posedge clk);
  endtask
  // ----------------------------------------
  // Answer monitor and hang guard
  // ----------------------------------------
  always @(negedge clk) begin
    if (ack === 1'b1) begin
      if (q.size() == 0) begin
        failures++;
      end else begin
        e = q.pop_front();
        chk({15'h0000, refd}, {15'h0000, e[16]});
        if (!e[17]) chk(p_rd, e[15:0]);
      end
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      failures++;
      results();
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    wait_idle();
    par(1'b0, `ADDR_RATED_CURRENT, 16'h0, 1'b0, 1'b0, RC);
    par(1'b1, `ADDR_RATED_CURRENT, 16'h0001, 1'b0, 1'b1, 16'h0);
    par(1'b0, `ADDR_VOLTAGE_RATING, 16'h0, 1'b0, 1'b0, VR);
    par(1'b0, `ADDR_SW_SUBVERSION, 16'h0, 1'b0, 1'b0, {8'h00, SUB});
    par(1'b1, `ADDR_SP_VERSION, 16'h0001, 1'b0, 1'b1, 16'h0);
    par(1'b0, `ADDR_SP_VERSION, 16'h0, 1'b0, 1'b0, {8'h00, SPV});
    par(1'b0, `ADDR_REVERT_TIMEOUT, 16'h0, 1'b0, 1'b0, 16'h00f0);
    par(1'b0, 12'h7ff, 16'h0, 1'b0, 1'b0, 16'h0000);
    par(1'b1, `ADDR_SECURITY_CODE, 16'h2710, 1'b0, 1'b1, 16'h0);
    par(1'b1, `ADDR_SECURITY_CODE, 16'h0005, 1'b0, 1'b0, 16'h0);
    par(1'b1, `ADDR_REVERT_TIMEOUT, 16'h0002, 1'b1, 1'b1, 16'h0);
    @(negedge clk);
    chk({15'h0000, lock}, 16'h0001);
    par(1'b1, `ADDR_SECURITY_CODE, 16'h0000, 1'b0, 1'b0, 16'h0);
    par(1'b1, `ADDR_REVERT_TIMEOUT, 16'h00fb, 1'b1, 1'b1, 16'h0);
    par(1'b1, `ADDR_REVERT_TIMEOUT, 16'h0002, 1'b1, 1'b0, 16'h0);
    @(posedge clk);
    kpad <= 1'b1;
    @(posedge clk);
    kpad <= 1'b0;
    repeat (12) @(posedge clk);
    chk({15'h0000, stat}, 16'h0000);
    repeat (20) @(posedge clk);
    chk({15'h0000, stat}, 16'h0001);
    for (int i = 0; i < 8; i++) save(i[5:0], rnd());
    key.mem[1] = 16'hffff;
    par(1'b1, `ADDR_CLONE_MODE, 16'h0002, 1'b0, 1'b0, 16'h0);
    @(posedge clk);
    rkey <= 1'b1;
    @(posedge clk);
    rkey <= 1'b0;
    wait_idle();
    chk(key.mem[0], RC);
    chk(key.mem[1], 16'h0000);
    for (int i = 0; i < 8; i++) chk(key.mem[i + 2], nv_exp[i]);
    chk({13'h0000, cmode}, 16'h0000);
    for (int t = 0; t < 2; t++) begin
      key.mem[1] = 16'hffff;
      par(1'b1, `ADDR_CLONE_MODE, 16'h0002, 1'b0, 1'b0, 16'h0);
      if (t == 0) begin
        par(1'b1, `ADDR_ACTION_CODE, `ACTION_RESET, 1'b0, 1'b0, 16'h0);
      end else begin
        @(posedge clk);
        rterm <= ~rterm;
      end
      wait_idle();
      chk(key.mem[1], 16'h0000);
      chk({13'h0000, cmode}, 16'h0000);
    end
    par(1'b1, `ADDR_CLONE_MODE, 16'h0003, 1'b0, 1'b0, 16'h0);
    save(6'h05, rnd());
    repeat (3) @(posedge clk);
    chk(key.mem[7], nv_exp[5]);
    chk({13'h0000, cmode}, 16'h0003);
    key.mem[0] = RC ^ 16'h0001;
    for (int i = 0; i < 8; i++) key.mem[i + 2] = rnd();
    par(1'b1, `ADDR_CLONE_MODE, 16'h0001, 1'b0, 1'b0, 16'h0);
    par(1'b1, `ADDR_RESET_FLAG, `RESET_FLAG_GO, 1'b0, 1'b0, 16'h0);
    repeat (4) @(posedge clk);
    chk({15'h0000, busy}, 16'h0000);
    chk({13'h0000, cmode}, 16'h0001);
    hs <= 3'h4 >> (rnd() % 3);
    par(1'b1, `ADDR_RESET_FLAG, `RESET_FLAG_GO, 1'b0, 1'b0, 16'h0);
    wait_idle();
    hs <= 3'h0;
    for (int i = 0; i < 8; i++) if (i != 3) nv_exp[i] = key.mem[i + 2];
    for (int i = 0; i < 8; i++) nv_chk(i[5:0]);
    chk({15'h0000, trip}, 16'h0001);
    chk({13'h0000, cmode}, 16'h0000);
    key.mem[0] = RC;
    key.mem[1] = 16'h0004;
    for (int i = 0; i < 64; i++) key.mem[i + 2] = rnd();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    wait_idle();
    for (int i = 0; i < 64; i++) nv_exp[i] = key.mem[i + 2];
    for (int i = 0; i < 64; i++) nv_chk(i[5:0]);
    chk({13'h0000, cmode}, 16'h0000);
    results();
  end
endmodule
